/* hdl/qsl_pkg.sv */
// shared constants, register map and pin bundle of the shift latch driver
package qsl_pkg;
  localparam int GROUPS = 4;
  localparam int STAGES = 8;
  localparam int CHANNELS = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int LEVEL_W = 5;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] SNAP_OFFSET = 8'h08;
  localparam logic [7:0] LIVE_OFFSET = 8'h0c;
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam int STATUS_DATA_BIT = 0;
  localparam int STATUS_OVERRUN_BIT = 1;
  localparam int STATUS_PENDING_BIT = 2;
  localparam int STATUS_LEVEL_LSB = 8;
  localparam logic CTRL_CAPTURE_RESET = 1'h0;
  localparam logic [CHANNELS-1:0] STAGE_RESET = 32'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [GROUPS-1:0] serial_in;
    logic shift_clk;
    logic latch_transfer;
    logic forward_shift;
    logic [GROUPS-1:0] force_low_n;
    logic output_sel;
    logic invert_sel;
  } qsl_pins_type;

  // every logic pin idles high when left open
  localparam qsl_pins_type PINS_PULLED = 13'h1fff;
endpackage : qsl_pkg

/* hdl/qsl_driver.sv */
// snapshot fifo and the 32-channel shift, latch and output driver
//
// Behaviour
// - four groups of eight shift stages
// - all four serial bits sampled on one edge
// - shift only on rising shift clock edge
// - direction high forward, low reverse, all groups
// - shifting ignores the latch control
// - latch high: latches follow the stages
// - latch low: latches hold their value
// - open logic inputs read as high
// - group force-low with invert high drives group low
`timescale 1ns/1ps

module qsl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int LEVEL_W = 5
) (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // filling side
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [LEVEL_W-1:0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [DEPTH-1:0][WIDTH-1:0] store;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = level != LEVEL_W'(DEPTH);
  assign out_valid = level != '0;
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule : qsl_fifo

module qsl_driver
  import qsl_pkg::*;
(
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // controller pins, asynchronous to aclk
  input qsl_pins_type pins,
  // axi4-lite write address
  input logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // axi4-lite read address
  input logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // channel outputs
  output logic [CHANNELS-1:0] drive_output
);
  qsl_pins_type pin_meta;
  qsl_pins_type pin_s;
  logic clk_prev;
  logic latch_prev;
  logic shift_rise;
  logic latch_fall;
  logic [GROUPS-1:0][STAGES-1:0] stages;
  logic [CHANNELS-1:0] latched;
  logic [CHANNELS-1:0] next_drive;
  logic capture_en;
  logic pending;
  logic [CHANNELS-1:0] pending_word;
  logic overrun;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [CHANNELS-1:0] fifo_out_data;
  logic [LEVEL_W-1:0] fifo_level;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic ar_take;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] status_word;

  // two-stage synchroniser; pulled-high idle value under reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= PINS_PULLED;
      pin_s <= PINS_PULLED;
      clk_prev <= 1'b1;
      latch_prev <= 1'b1;
    end else begin
      pin_meta <= pins;
      pin_s <= pin_meta;
      clk_prev <= pin_s.shift_clk;
      latch_prev <= pin_s.latch_transfer;
    end
  end

  assign shift_rise = pin_s.shift_clk && !clk_prev;
  assign latch_fall = !pin_s.latch_transfer && latch_prev;

  // one shift register per group, all clocked by the same edge
  for (genvar g = 0; g < GROUPS; g++) begin : g_group
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stages[g] <= STAGE_RESET[g*STAGES +: STAGES];
      end else if (shift_rise) begin
        if (pin_s.forward_shift) begin
          stages[g] <= {stages[g][STAGES-2:0], pin_s.serial_in[g]};
        end else begin
          stages[g] <= {pin_s.serial_in[g], stages[g][STAGES-1:1]};
        end
      end
    end

    always_comb begin
      if (!pin_s.output_sel) begin
        next_drive[g*STAGES +: STAGES] = {STAGES{!pin_s.invert_sel}};
      end else if (!pin_s.force_low_n[g] && pin_s.invert_sel) begin
        next_drive[g*STAGES +: STAGES] = '0;
      end else if (pin_s.invert_sel) begin
        next_drive[g*STAGES +: STAGES] = latched[g*STAGES +: STAGES];
      end else begin
        next_drive[g*STAGES +: STAGES] = ~latched[g*STAGES +: STAGES];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched <= STAGE_RESET;
    end else if (pin_s.latch_transfer) begin
      latched <= stages;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_output <= STAGE_RESET;
    end else begin
      drive_output <= next_drive;
    end
  end

  // a held latch word is queued for software; a full fifo stalls the hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= 1'b0;
      pending_word <= '0;
    end else if (latch_fall && capture_en && !(pending && !fifo_in_ready)) begin
      pending <= 1'b1;
      pending_word <= latched;
    end else if (fifo_in_ready) begin
      pending <= 1'b0;
    end
  end

  qsl_fifo #(
    .WIDTH(CHANNELS),
    .DEPTH(FIFO_DEPTH),
    .LEVEL_W(LEVEL_W)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(pending),
    .in_ready(fifo_in_ready),
    .in_data(pending_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == CTRL_OFFSET || aw_addr == STATUS_OFFSET) ?
          RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_en <= CTRL_CAPTURE_RESET;
    end else if (do_write && aw_addr == CTRL_OFFSET && w_strb[0]) begin
      capture_en <= w_data[CTRL_CAPTURE_BIT];
    end
  end

  // sticky overrun: a new capture arriving while the hold is stalled; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun <= 1'b0;
    end else if (latch_fall && capture_en && pending && !fifo_in_ready) begin
      overrun <= 1'b1;
    end else if (do_write && aw_addr == STATUS_OFFSET && w_strb[0] &&
                 w_data[STATUS_OVERRUN_BIT]) begin
      overrun <= 1'b0;
    end
  end

  // read channel
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign fifo_pop = ar_take && s_axi_araddr == SNAP_OFFSET && fifo_out_valid;

  always_comb begin
    status_word = '0;
    status_word[STATUS_DATA_BIT] = fifo_out_valid;
    status_word[STATUS_OVERRUN_BIT] = overrun;
    status_word[STATUS_PENDING_BIT] = pending;
    status_word[STATUS_LEVEL_LSB +: LEVEL_W] = fifo_level;
    next_rresp = RESP_OKAY;
    case (s_axi_araddr)
      CTRL_OFFSET: next_rdata = {31'h0, capture_en};
      STATUS_OFFSET: next_rdata = status_word;
      SNAP_OFFSET: next_rdata = fifo_out_valid ? fifo_out_data : 32'h0;
      LIVE_OFFSET: next_rdata = drive_output;
      default: begin
        next_rdata = 32'h0;
        next_rresp = RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : qsl_driver

/* testbench/qsl_driver_assertions.sv */
// concurrent checks on the pins, bus and channel outputs of the driver
`timescale 1ns/1ps
module qsl_driver_assertions
  import qsl_pkg::*;
(
  // clock, reset and controller pins
  input logic aclk,
  input logic aresetn,
  input qsl_pins_type pins,
  // axi4-lite
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  // channel outputs
  input logic [CHANNELS-1:0] drive_output
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_outputs_forced: assert property (
    (!pins.output_sel && $stable(pins.invert_sel))[*3]
    |=> drive_output == {CHANNELS{~$past(pins.invert_sel, 3)}}) else $error("forced level wrong");
  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    a_group_low: assert property (
      (pins.output_sel && pins.invert_sel && !pins.force_low_n[g])[*3]
      |=> drive_output[g*8 +: 8] == 8'h00) else $error("group not forced low");
  end
  a_latch_hold: assert property (
    (!pins.latch_transfer && $stable(pins[5:0]))[*5]
    |=> $stable(drive_output)) else $error("output moved while latch closed");
  // both halves held at the take edge, response launched one edge later, seen the next
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 (s_axi_bvalid && s_axi_bresp == (($past(s_axi_awaddr, 2) == CTRL_OFFSET ||
    $past(s_axi_awaddr, 2) == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR)))
    else $error("write response wrong");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rresp == ($past(s_axi_araddr) > LIVE_OFFSET ?
    RESP_SLVERR : RESP_OKAY)) else $error("read response wrong");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write not closed");
endmodule : qsl_driver_assertions

bind qsl_driver qsl_driver_assertions qsl_driver_assertions_inst (.*);

/* testbench/qsl_ctrl_model.sv */
// display controller model driving the serial and control pins
`timescale 1ns/1ps
module qsl_ctrl_model
  import qsl_pkg::*;
(
  // clock
  input logic aclk,
  // controller pins
  output qsl_pins_type pins
);
  // open pins read high; the shift clock rests low between transfers
  initial begin
    pins = PINS_PULLED;
    pins.shift_clk = 1'h0;
  end
  // control byte is latch, direction, force_low_n, output_sel, invert_sel
  task automatic set_ctrl(input logic [7:0] c);
    pins[7:0] <= c;
    repeat (6) @(posedge aclk);
  endtask : set_ctrl
  // four bits together, held well around the rising shift clock
  task automatic shift(input logic [GROUPS-1:0] d);
    pins.serial_in <= d;
    repeat (4) @(posedge aclk);
    pins.shift_clk <= 1'h1;
    repeat (4) @(posedge aclk);
    pins.shift_clk <= 1'h0;
    repeat (4) @(posedge aclk);
    pins.serial_in <= ~d;
    @(posedge aclk);
  endtask : shift
endmodule : qsl_ctrl_model

/* testbench/qsl_driver_tb_top.sv */
// self-checking bench of the shift latch driver
`timescale 1ns/1ps
module qsl_driver_tb_top
  import qsl_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st = 32'h0, lat = 32'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [CHANNELS-1:0] drive_output;
  logic [7:0] codes[8] = '{8'hff, 8'hfe, 8'hfb, 8'hc3, 8'hc2, 8'hfd, 8'hfc, 8'hff};
  qsl_pins_type pins;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_errors = 0, compares = 0;
  always #2 aclk = ~aclk;
  qsl_ctrl_model qsl_ctrl_model_inst (.aclk(aclk), .pins(pins));
  qsl_driver qsl_driver_inst (.*);
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk_read(input logic [33:0] e, input logic [33:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] read expected %h seen %h", e, s);
    end
  endtask : chk_read
  task automatic chk_resp(input logic [1:0] e, input logic [1:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] bresp expected %h seen %h", e, s);
    end
  endtask : chk_resp
  task automatic chk_out(input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] drive_output expected %h seen %h", e, s);
    end
  endtask : chk_out
  task automatic hang(input logic ok);
    if (ok !== 1'h1) begin
      n_errors++;
      end_of_test;
    end
  endtask : hang
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk_read(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk_resp(bq.pop_front(), s_axi_bresp);
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 99);
    hang(s_axi_bvalid);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 99);
    hang(s_axi_rvalid);
  endtask : rd
  function automatic logic [31:0] expect_out(input logic [31:0] l, input logic [7:0] c);
    for (int g = 0; g < GROUPS; g++)
      expect_out[g*8 +: 8] = !c[1] ? {8{~c[0]}} : (!c[2+g] && c[0]) ? 8'h00 :
        c[0] ? l[g*8 +: 8] : ~l[g*8 +: 8];
  endfunction : expect_out
  initial begin
    logic [31:0] d;
    void'($urandom(32'h90da));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(CTRL_OFFSET, {RESP_OKAY, 32'h0});
    rd(LIVE_OFFSET, {RESP_OKAY, 32'h0});
    rd(8'h10, {RESP_SLVERR, 32'h0});
    wr(SNAP_OFFSET, 32'h1, RESP_SLVERR);
    // forward open, reverse open, reverse with latch closed
    for (int k = 0; k < 3; k++) begin
      qsl_ctrl_model_inst.set_ctrl({k != 2, k == 0, 6'h3f});
      repeat (8) begin
        d = $urandom;
        qsl_ctrl_model_inst.shift(d[3:0]);
        for (int g = 0; g < GROUPS; g++)
          st[g*8 +: 8] = k ? {d[g], st[g*8+1 +: 7]} : {st[g*8 +: 7], d[g]};
        if (k != 2) lat = st;
      end
      rd(LIVE_OFFSET, {RESP_OKAY, lat});
      chk_out(lat, drive_output);
    end
    lat = st;
    foreach (codes[i]) begin
      qsl_ctrl_model_inst.set_ctrl(codes[i]);
      chk_out(expect_out(lat, codes[i]), drive_output);
      rd(LIVE_OFFSET, {RESP_OKAY, expect_out(lat, codes[i])});
    end
    // eighteen captures: sixteen fill the fifo, one waits, one is dropped
    wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
    repeat (18) begin
      qsl_ctrl_model_inst.set_ctrl(8'h7f);
      qsl_ctrl_model_inst.set_ctrl(8'hff);
    end
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h1007});
    repeat (17) rd(SNAP_OFFSET, {RESP_OKAY, lat});
    rd(SNAP_OFFSET, {RESP_OKAY, 32'h0});
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h2});
    wr(STATUS_OFFSET, 32'h2, RESP_OKAY);
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h0});
    @(posedge aclk);
    end_of_test;
  end
endmodule : qsl_driver_tb_top
